// file: common/gpb_map.vh
// Register map and constants for the 24-pin general-purpose port block.
// Assumes a 32-bit byte-addressed Avalon-MM slave; offsets are byte addresses.
`ifndef GPB_MAP_VH
`define GPB_MAP_VH

`define GPB_OFF_DIR 8'h00
`define GPB_OFF_PIN 8'h04
`define GPB_OFF_OUT 8'h08
`define GPB_OFF_CLR 8'h0C
`define GPB_OFF_PU 8'h10
`define GPB_OFF_PDDRV 8'h14
`define GPB_OFF_TRIG 8'h18
`define GPB_OFF_FLAG 8'h1C
`define GPB_RST_CFG 24'h000000
`define GPB_UNMAPPED_RD 32'h00000000

`endif

// file: core/gpb_pin_detect.v
// Per-pin interrupt condition detector for the port block.
// Assumes pin levels are synchronous to clk_i; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module gpb_pin_detect #(
	parameter WIDTH = 24
) (
	input wire clk_i,
	input wire rst_b_i,
	input wire [WIDTH-1:0] level_i,
	input wire [WIDTH-1:0] is_input_i,
	input wire [WIDTH-1:0] polarity_i,
	input wire [WIDTH-1:0] edge_mode_i,
	output wire [WIDTH-1:0] hit_o
);
	reg [WIDTH-1:0] prev_reg;
	genvar g;

	// Previous level, kept for edge detection
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			prev_reg <= {WIDTH{1'b0}};
		end else begin
			prev_reg <= level_i;
		end
	end

	// Level or edge of chosen polarity, only on input pins
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
			wire act_now = polarity_i[g] ? level_i[g] : ~level_i[g];
			wire act_prev = polarity_i[g] ? prev_reg[g] : ~prev_reg[g];
			assign hit_o[g] = is_input_i[g] &
				(edge_mode_i[g] ? (act_now & ~act_prev) : act_now); // R4 R12
		end
	endgenerate
endmodule // gpb_pin_detect
`default_nettype wire

// file: core/gpb_port.v
// Register bank and pin control for a 24-pin general-purpose port.
// Assumes an Avalon-MM master on clk_i and pin levels synchronous to clk_i.
// Function
// R1: A direction bit of 1 makes its pin an output, 0 an input.
// R2: The pin input register reads 1 for a high pin and 0 for a low one.
// R3: An output pin is driven high or low by its output data bit.
// R4: On an input pin the output data bit selects interrupt polarity.
// R5: Writing 1 to an output-clear bit zeroes that output bit, 0 does nothing.
// R6: A pull-up bit of 1 turns on the pin's pull-up control.
// R7: On an input pin the pull-down/drive bit of 1 turns on the pull-down.
// R8: On an output pin the pull-down/drive bit of 1 selects strong drive.
// R9: All three configuration bits at 0 leave the pin floating.
// R10: Input with pull-up or pull-down follows the pull-up and pull-down bits.
// R11: Direction 1 gives push-pull output regardless of the pull-up bit.
// R12: The trigger type bit chooses edge (1) or level (0) detection.
// R13: Detected conditions set a flag that software clears by writing 1.
// R14: Reserved bits read zero, and configuration resets to zero.
`timescale 1ns/1ps
`default_nettype none
`include "gpb_map.vh"
module gpb_port #(
	parameter WIDTH = 24
) (
	input wire clk_i,
	input wire rst_b_i,
	input wire [7:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	input wire [WIDTH-1:0] pin_level_i,
	output reg [WIDTH-1:0] pin_out_o,
	output reg [WIDTH-1:0] pin_oe_o,
	output reg [WIDTH-1:0] pin_pull_up_o,
	output reg [WIDTH-1:0] pin_pull_down_o,
	output reg [WIDTH-1:0] pin_strong_drive_o,
	output wire [WIDTH-1:0] flag_o
);
	reg [WIDTH-1:0] direction_bits_reg;
	reg [WIDTH-1:0] output_data_bits_reg;
	reg [WIDTH-1:0] pull_up_bits_reg;
	reg [WIDTH-1:0] pull_down_drive_bits_reg;
	reg [WIDTH-1:0] interrupt_trigger_type_bits_reg;
	reg [WIDTH-1:0] interrupt_flag_bits_reg;
	reg [WIDTH-1:0] interrupt_flag_bits_next;
	reg [WIDTH-1:0] output_data_bits_next;
	reg ack_reg;
	reg [31:0] rd_next;
	wire [31:0] be_mask;
	wire [31:0] wmask_full;
	wire [WIDTH-1:0] wmask;
	wire [WIDTH-1:0] wdata;
	wire [WIDTH-1:0] hit;
	wire wr_go;
	wire rd_go;

	// One wait cycle per access: ack on the cycle after request
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
	assign wr_go = avs_write_i & ack_reg;
	assign rd_go = avs_read_i & ~ack_reg;

	// Byte enables widened to a bit mask; upper bits dropped (R14)
	assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
		{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	assign wmask_full = be_mask & avs_writedata_i;
	assign wmask = be_mask[WIDTH-1:0];
	assign wdata = avs_writedata_i[WIDTH-1:0];
	assign flag_o = interrupt_flag_bits_reg;

	// Handshake phase toggles so each request completes once
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			ack_reg <= 1'b0;
		end else if (ack_reg) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= avs_read_i | avs_write_i;
		end
	end

	// Condition detector on the pins
	gpb_pin_detect #(
		.WIDTH(WIDTH)
	) u_detect (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.level_i(pin_level_i),
		.is_input_i(~direction_bits_reg),
		.polarity_i(output_data_bits_reg),
		.edge_mode_i(interrupt_trigger_type_bits_reg),
		.hit_o(hit)
	);

	// Output data next value: write, then clear-on-one
	always @* begin
		output_data_bits_next = output_data_bits_reg;
		if (wr_go && avs_address_i == `GPB_OFF_OUT) begin
			output_data_bits_next = (output_data_bits_reg & ~wmask) |
				(wdata & wmask);
		end else if (wr_go && avs_address_i == `GPB_OFF_CLR) begin
			output_data_bits_next = output_data_bits_reg &
				~wmask_full[WIDTH-1:0]; // R5
		end
	end

	// Flag next value: a new hit wins over a clear in the same cycle
	always @* begin
		interrupt_flag_bits_next = interrupt_flag_bits_reg;
		if (wr_go && avs_address_i == `GPB_OFF_FLAG) begin
			interrupt_flag_bits_next = interrupt_flag_bits_reg &
				~wmask_full[WIDTH-1:0]; // R13
		end
		interrupt_flag_bits_next = interrupt_flag_bits_next | hit; // R13
	end

	// Configuration registers, all zero after reset
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			direction_bits_reg <= `GPB_RST_CFG; // R14
			output_data_bits_reg <= `GPB_RST_CFG;
			pull_up_bits_reg <= `GPB_RST_CFG;
			pull_down_drive_bits_reg <= `GPB_RST_CFG;
			interrupt_trigger_type_bits_reg <= `GPB_RST_CFG;
			interrupt_flag_bits_reg <= `GPB_RST_CFG;
		end else begin
			output_data_bits_reg <= output_data_bits_next;
			interrupt_flag_bits_reg <= interrupt_flag_bits_next;
			if (wr_go) begin
				if (avs_address_i == `GPB_OFF_DIR) begin
					direction_bits_reg <= (direction_bits_reg & ~wmask) |
						(wdata & wmask); // R1
				end else if (avs_address_i == `GPB_OFF_PU) begin
					pull_up_bits_reg <= (pull_up_bits_reg & ~wmask) |
						(wdata & wmask); // R6
				end else if (avs_address_i == `GPB_OFF_PDDRV) begin
					pull_down_drive_bits_reg <=
						(pull_down_drive_bits_reg & ~wmask) | (wdata & wmask);
				end else if (avs_address_i == `GPB_OFF_TRIG) begin
					interrupt_trigger_type_bits_reg <=
						(interrupt_trigger_type_bits_reg & ~wmask) |
						(wdata & wmask); // R12
				end
			end
		end
	end

	// Pin mode table; the pull-up bit is ignored on outputs
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			pin_out_o <= `GPB_RST_CFG;
			pin_oe_o <= `GPB_RST_CFG; // R9
			pin_pull_up_o <= `GPB_RST_CFG;
			pin_pull_down_o <= `GPB_RST_CFG;
			pin_strong_drive_o <= `GPB_RST_CFG;
		end else begin
			pin_oe_o <= direction_bits_reg; // R1 R11
			pin_out_o <= output_data_bits_reg & direction_bits_reg; // R3
			pin_pull_up_o <= pull_up_bits_reg & ~direction_bits_reg; // R6 R10
			pin_pull_down_o <= pull_down_drive_bits_reg &
				~direction_bits_reg; // R7 R10
			pin_strong_drive_o <= pull_down_drive_bits_reg &
				direction_bits_reg; // R8
		end
	end

	// Read mux; reserved and unmapped read as zero
	always @* begin
		rd_next = `GPB_UNMAPPED_RD;
		if (avs_address_i == `GPB_OFF_DIR) begin
			rd_next[WIDTH-1:0] = direction_bits_reg;
		end else if (avs_address_i == `GPB_OFF_PIN) begin
			rd_next[WIDTH-1:0] = pin_level_i; // R2
		end else if (avs_address_i == `GPB_OFF_OUT) begin
			rd_next[WIDTH-1:0] = output_data_bits_reg;
		end else if (avs_address_i == `GPB_OFF_PU) begin
			rd_next[WIDTH-1:0] = pull_up_bits_reg;
		end else if (avs_address_i == `GPB_OFF_PDDRV) begin
			rd_next[WIDTH-1:0] = pull_down_drive_bits_reg;
		end else if (avs_address_i == `GPB_OFF_TRIG) begin
			rd_next[WIDTH-1:0] = interrupt_trigger_type_bits_reg;
		end else if (avs_address_i == `GPB_OFF_FLAG) begin
			rd_next[WIDTH-1:0] = interrupt_flag_bits_reg;
		end
	end

	// Read data captured so it stands when waitrequest falls
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			avs_readdata_o <= `GPB_UNMAPPED_RD;
		end else if (rd_go) begin
			avs_readdata_o <= rd_next; // R14
		end
	end
endmodule // gpb_port
`default_nettype wire

// file: tb/gpb_board.sv
// Board model: drives pin levels from the port's outputs or bench drivers.
// Assumes levels are registered on clk_i; floating pins toggle each cycle.
`timescale 1ns/1ps
`default_nettype none
module gpb_board (
	input wire logic clk_i,
	input wire logic [23:0] out_i,
	input wire logic [23:0] oe_i,
	input wire logic [23:0] pu_i,
	input wire logic [23:0] pd_i,
	input wire logic [23:0] ext_i,
	input wire logic [23:0] ext_en_i,
	output logic [23:0] level_o
);
	// Per pin: own driver first, then bench, then resistors
	// A floating pin starts from 1 when its level is still unknown
	always_ff @(posedge clk_i) begin
		for (int k = 0; k < 24; k++) begin
			if (oe_i[k])
				level_o[k] <= out_i[k];
			else if (ext_en_i[k])
				level_o[k] <= ext_i[k];
			else if (pu_i[k] | pd_i[k])
				level_o[k] <= pu_i[k];
			else
				level_o[k] <= (level_o[k] === 1'b1) ? 1'b0 : 1'b1;
		end
	end
endmodule // gpb_board
`default_nettype wire

// file: tb/gpb_port_monitor.sv
// Bus and pin-output assertions for the port block, bound into gpb_port.
// Assumes one clock, sync active-low reset and all byte enables on.
`timescale 1ns/1ps
`default_nettype none
module gpb_port_monitor #(
	parameter WIDTH = 24
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [WIDTH-1:0] pin_out_o,
	input wire logic [WIDTH-1:0] pin_oe_o,
	input wire logic [WIDTH-1:0] pin_pull_up_o,
	input wire logic [WIDTH-1:0] pin_pull_down_o,
	input wire logic [WIDTH-1:0] pin_strong_drive_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// Write data kept one cycle so pin effects can be traced to it
	logic [WIDTH-1:0] wd_reg;
	wire wdone = avs_write_i && !avs_waitrequest_o;
	always_ff @(posedge clk_i) begin
		wd_reg <= avs_writedata_i[WIDTH-1:0];
	end
	property p_out_gated;
		(pin_out_o & ~pin_oe_o) == '0;
	endproperty
	a_out_gated: assert property (p_out_gated) else $error("out on input");
	property p_pu_in;
		(pin_pull_up_o & pin_oe_o) == '0;
	endproperty
	a_pu_in: assert property (p_pu_in) else $error("pull-up on output");
	property p_pd_in;
		(pin_pull_down_o & pin_oe_o) == '0;
	endproperty
	a_pd_in: assert property (p_pd_in) else $error("pull-down on output");
	property p_drv_out;
		(pin_strong_drive_o & ~pin_oe_o) == '0;
	endproperty
	a_drv_out: assert property (p_drv_out) else $error("drive on input");
	property p_dir;
		wdone && avs_address_i == 8'h00 |=> ##1 pin_oe_o == $past(wd_reg);
	endproperty
	a_dir: assert property (p_dir) else $error("direction not applied");
	property p_clr;
		wdone && avs_address_i == 8'h0C |=> ##1 (pin_out_o & $past(wd_reg)) == '0;
	endproperty
	a_clr: assert property (p_clr) else $error("clear not applied");
	property p_rsv;
		avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:24] == 8'h00;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_wait;
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	a_wait: assert property (p_wait) else $error("answer late");
endmodule // gpb_port_monitor
bind gpb_port gpb_port_monitor #(.WIDTH(WIDTH)) i_gpb_port_monitor (.*);
`default_nettype wire

// file: tb/test_gpb_port.sv
// Self-checking bench for gpb_port over Avalon-MM with a board model.
// Assumes 100 MHz clock; byte enables held on, so masking is not exercised.
`timescale 1ns/1ps
`default_nettype none
module test_gpb_port;
	logic clk_i = 0, rst_b_i = 0, avs_read_i = 0, avs_write_i = 0;
	logic [7:0] avs_address_i = 8'h00;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
	logic avs_waitrequest_o;
	logic [23:0] pin_level_i, pin_out_o, pin_oe_o, pin_pull_up_o, flag_o;
	logic [23:0] pin_pull_down_o, pin_strong_drive_o;
	logic [23:0] ext = 24'h0, ext_en = 24'h0;
	int fails = 0, n_compared = 0;
	always #5 clk_i = ~clk_i;
	gpb_port i_gpb_port (.*);
	gpb_board i_gpb_board (.clk_i, .out_i(pin_out_o), .oe_i(pin_oe_o),
		.pu_i(pin_pull_up_o), .pd_i(pin_pull_down_o), .ext_i(ext),
		.ext_en_i(ext_en), .level_o(pin_level_i));
	// One bus access; held until waitrequest is seen low
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		// Waitrequest and read data are sampled at the rising edge only
		@(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
		q = avs_readdata_o;
		avs_write_i <= 0;
		avs_read_i <= 0;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		bus(0, a, 32'h0);
		chk(n, e, q);
	endtask
	task t_reset;
		rdc("dir", 8'h00, 32'h0);
		rdc("out", 8'h08, 32'h0);
		rdc("pu", 8'h10, 32'h0);
		rdc("pdd", 8'h14, 32'h0);
		rdc("clr", 8'h0C, 32'h0);
		rdc("unmapped", 8'h40, 32'h0);
		chk("oe", 32'h0, {8'h00, pin_oe_o | pin_pull_up_o});
	endtask
	task t_out;
		bus(1, 8'h00, 32'hFFF0F0F0);
		rdc("dir", 8'h00, 32'h00F0F0F0);
		bus(1, 8'h08, 32'h00FFFFFF);
		bus(1, 8'h0C, 32'h000000F0);
		rdc("out", 8'h08, 32'h00FFFF0F);
		chk("pin_out", 32'h00F0F000, {8'h00, pin_out_o});
		bus(1, 8'h0C, 32'h00FFFFFF);
	endtask
	task t_pull;
		bus(1, 8'h00, 32'h000000FF);
		bus(1, 8'h10, 32'h00FF0F0F);
		bus(1, 8'h14, 32'h0000F0F0);
		// Pin outputs follow the register one cycle after the write edge
		repeat (2) @(posedge clk_i);
		chk("pull_up", 32'h00FF0F00, {8'h00, pin_pull_up_o});
		chk("pull_dn", 32'h0000F000, {8'h00, pin_pull_down_o});
		chk("strong", 32'h000000F0, {8'h00, pin_strong_drive_o});
		rdc("pin", 8'h04, 32'h00FF0F00);
		ext <= 24'h005A00;
		ext_en <= 24'h00FF00;
		rdc("pin_ext", 8'h04, 32'h00FF5A00);
	endtask
	// Bit 1 low-level mode re-sets; bit 0 rising edge sets once
	task t_flag;
		ext <= 24'h0;
		ext_en <= 24'hFFFFFF;
		bus(1, 8'h00, 32'h0);
		bus(1, 8'h08, 32'h00FFFFFD);
		bus(1, 8'h18, 32'h00000001);
		bus(1, 8'h1C, 32'h00FFFFFF);
		repeat (2) @(negedge clk_i);
		chk("flag_lvl", 32'h2, {8'h00, flag_o});
		@(posedge clk_i);
		ext <= 24'h000003;
		repeat (3) @(posedge clk_i);
		bus(1, 8'h1C, 32'h00000002);
		repeat (2) @(negedge clk_i);
		chk("flag_edge", 32'h1, {8'h00, flag_o});
		bus(1, 8'h1C, 32'h00000001);
		repeat (2) @(negedge clk_i);
		chk("flag_clr", 32'h0, {8'h00, flag_o});
	endtask
	task final_report;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1;
		t_reset;
		t_out;
		t_pull;
		t_flag;
		final_report;
	end
	// Whole run is under a hundred cycles; this only cuts a hang
	initial begin
		repeat (5000) @(posedge clk_i);
		fails++;
		final_report;
	end
endmodule // test_gpb_port
`default_nettype wire
